// File: csms_top.sv
// clocked serial master sequencer: control, buffers, flags, crossings
`timescale 1ns/1ps
module csms_top
  import csms_pkg::*;
// Functional notes
// - enable bits and power may share write
// - no transmit, receive plus continue: receive-only
// - transmit buffer write starts a transfer
// - receive read never starts when transmitting
// - single modes: no tx irq, rx irq
// - single data-phase: ignore write while active
// - receive-only: buffer read triggers reception
// - single receive: each read retriggers
// - clock-continue cleared: no further reception
// - continuous transmit: tx irq on load
// - continuous receive overrun sets flag, irq
// - length zero means 8 bits, order from bit_order_select
// - length 8 to 16, right-aligned data
// - active flag clears at last edge
// - write zero clears overrun, one ignored
// - overrun overwrites receive buffer
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              link_clk,
  input  wire logic              unit_power_enable,
  input  wire logic              transmit_enable_bit,
  input  wire logic              receive_enable_bit,
  input  wire logic              clock_continue_enable,
  input  wire logic              bit_order_select,
  input  wire logic              transfer_mode_select,
  input  wire logic              data_phase_select,
  input  wire logic [LEN_W-1:0]  bit_length_field,
  input  wire logic              tx_write,
  input  wire logic [DATA_W-1:0] tx_wdata,
  input  wire logic              rx_read,
  input  wire logic              overrun_write,
  input  wire logic              overrun_wdata,
  input  wire logic              sdi,
  output logic [DATA_W-1:0]      receive_buffer,
  output logic                   transfer_active_flag,
  output logic                   overrun_flag,
  output logic                   tx_enable_irq,
  output logic                   rx_complete_irq,
  output logic                   sck,
  output logic                   sdo
);
  ////////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] tx_q;
  logic              tx_full_q;
  logic [DATA_W-1:0] sh_word_q;
  logic [4:0]        nbits_q;
  logic              lsb_q;
  logic              start_tgl_q;
  logic              done_s;
  logic              done_seen_q;
  logic              rx_unread_q;
  logic              rx_pend_q;
  logic [DATA_W-1:0] link_rx;
  logic              link_done_tgl;
  logic              link_sck;
  logic              link_sdo;
  logic              done_ev;
  logic              tx_mode;
  logic              rx_only;
  logic              tx_accept;
  logic              rx_trig;
  logic              can_start;
  logic [4:0]        nbits_d;
  logic [11:0]       frame_cyc_q;

  assign tx_mode = transmit_enable_bit;
  assign rx_only = !transmit_enable_bit && receive_enable_bit
                   && clock_continue_enable;
  assign done_ev = done_s != done_seen_q;
  // length field: top bit forces 16, else 8 plus low bits
  assign nbits_d = bit_length_field[LEN_FULL_BIT] ? BITS_MAX
                   : BITS_MIN + {2'b00, bit_length_field[2:0]};
  // single data-phase mode drops writes while busy; enables may rise with power
  assign tx_accept = tx_write && unit_power_enable && tx_mode
                     && !(transfer_active_flag && !transfer_mode_select
                          && data_phase_select);
  // read triggers reception only in receive-only mode
  assign rx_trig = rx_read && unit_power_enable && rx_only;
  assign can_start = !transfer_active_flag || done_ev;

  ////////////////////////////////////////////////////////////////////////
  csms_sync u_done_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (link_done_tgl),
    .dout    (done_s)
  );

  csms_shifter u_shift (
    .link_clk  (link_clk),
    .reset_n   (reset_n),
    .start_tgl (start_tgl_q),
    .tx_word   (sh_word_q),
    .nbits     (nbits_q),
    .lsb_first (lsb_q),
    .sdi       (sdi),
    .sck       (link_sck),
    .sdo       (link_sdo),
    .done_tgl  (link_done_tgl),
    .rx_word   (link_rx)
  );

  // pins come straight from the shifter flops; a second stage would skew sdi sampling
  assign sck = link_sck;
  assign sdo = link_sdo;

  ////////////////////////////////////////////////////////////////////////
  // transmit holding buffer; continuous mode may preload during a frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_q      <= TX_RESET;
      tx_full_q <= 1'b0;
    end else if (!unit_power_enable) begin
      tx_full_q <= 1'b0;
    end else if (tx_accept) begin
      tx_q      <= tx_wdata;
      tx_full_q <= 1'b1;
    end else if (tx_full_q && can_start) begin
      tx_full_q <= 1'b0;
    end
  end

  // frame launch and active flag; word is stable before toggle crosses
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_word_q            <= TX_RESET;
      nbits_q              <= BITS_MIN;
      lsb_q                <= 1'b0;
      start_tgl_q          <= 1'b0;
      done_seen_q          <= 1'b0;
      transfer_active_flag <= 1'b0;
      rx_pend_q            <= 1'b0;
      tx_enable_irq        <= 1'b0;
    end else begin
      tx_enable_irq <= 1'b0;
      if (done_ev) begin
        done_seen_q          <= done_s;
        transfer_active_flag <= 1'b0;
      end
      // a read trigger waits for the running frame; continue gates it
      if (rx_trig && clock_continue_enable) begin
        rx_pend_q <= 1'b1;
      end
      if (!unit_power_enable) begin
        rx_pend_q <= 1'b0;
      end else if (can_start && tx_full_q && tx_mode) begin
        sh_word_q            <= tx_q;
        nbits_q              <= nbits_d;
        lsb_q                <= bit_order_select;
        start_tgl_q          <= ~start_tgl_q;
        transfer_active_flag <= 1'b1;
        tx_enable_irq        <= transfer_mode_select;
      end else if (can_start && rx_only
                   && (rx_pend_q || (transfer_mode_select && done_ev
                                     && clock_continue_enable))) begin
        // continuous receive restarts itself until continue is cleared
        sh_word_q            <= TX_RESET;
        nbits_q              <= nbits_d;
        lsb_q                <= bit_order_select;
        start_tgl_q          <= ~start_tgl_q;
        transfer_active_flag <= 1'b1;
        rx_pend_q            <= 1'b0;
      end
    end
  end

  // receive buffer, overrun and completion interrupt
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      receive_buffer  <= RX_RESET;
      rx_unread_q     <= 1'b0;
      overrun_flag    <= 1'b0;
      rx_complete_irq <= 1'b0;
    end else begin
      rx_complete_irq <= 1'b0;
      if (!unit_power_enable) begin
        overrun_flag <= 1'b0;
        rx_unread_q  <= 1'b0;
      end else if (done_ev) begin
        receive_buffer <= link_rx;
        rx_unread_q    <= 1'b1;
        // set wins over a same-cycle software clear
        if (rx_unread_q && receive_enable_bit) begin
          overrun_flag    <= 1'b1;
          rx_complete_irq <= transfer_mode_select;
        end else begin
          rx_complete_irq <= 1'b1;
          if (overrun_write && !overrun_wdata) begin
            overrun_flag <= 1'b0;
          end
        end
      end else begin
        if (rx_read) begin
          rx_unread_q <= 1'b0;
        end
        if (overrun_write && !overrun_wdata) begin
          overrun_flag <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tx enable pulse only in continuous transmit
  AST_NO_TXIRQ_SINGLE: assert property (@(posedge clk) disable iff (!reset_n)
    tx_enable_irq |-> $past(transfer_mode_select))
    else $error("tx irq in single mode");

  AST_TX_STARTS: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_accept && !transfer_active_flag && unit_power_enable && !tx_full_q)
      |=> ##[0:2] transfer_active_flag)
    else $error("tx write did not start transfer");

  AST_READ_NO_START_TX: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_read && transmit_enable_bit && !tx_full_q && !transfer_active_flag)
      |=> !transfer_active_flag)
    else $error("receive read started a transfer");

  AST_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_write && transfer_active_flag && !transfer_mode_select && data_phase_select)
      |=> $stable(tx_q))
    else $error("write taken while busy");

  AST_RXONLY_TRIG: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_trig && clock_continue_enable && !transfer_active_flag)
      |=> ##[0:1] transfer_active_flag)
    else $error("read did not trigger reception");

  AST_NO_CONT_STOP: assert property (@(posedge clk) disable iff (!reset_n)
    (!transfer_active_flag && !clock_continue_enable && !tx_full_q && !rx_pend_q
     && !done_ev) |=> !transfer_active_flag)
    else $error("reception started without continue");

  AST_OVR_IRQ: assert property (@(posedge clk) disable iff (!reset_n)
    (done_ev && unit_power_enable && rx_unread_q && receive_enable_bit)
      |=> overrun_flag && (rx_complete_irq == $past(transfer_mode_select)))
    else $error("overrun not flagged");

  AST_OVR_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    (overrun_write && overrun_wdata && !done_ev && !overrun_flag) |=> !overrun_flag)
    else $error("writing one set overrun");

  AST_ACTIVE_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    (done_ev && !(tx_full_q && tx_mode) && !rx_pend_q && !transfer_mode_select)
      |=> !transfer_active_flag)
    else $error("active flag not cleared at end");

  // cycles spent in the current frame; a stuck link shows up here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_cyc_q <= 12'h000;
    end else if (!transfer_active_flag || done_ev) begin
      frame_cyc_q <= 12'h000;
    end else if (frame_cyc_q != FRAME_CYC_MAX) begin
      frame_cyc_q <= frame_cyc_q + 12'h001;
    end
  end

  // steps of a launch and of a frame end
  sequence seq_write_idle;
    tx_accept && !transfer_active_flag && !tx_full_q;
  endsequence

  sequence seq_active_soon;
    ##[1:3] transfer_active_flag;
  endsequence

  sequence seq_frame_end;
    done_ev && unit_power_enable;
  endsequence

  sequence seq_buffer_loaded;
    ##1 (receive_buffer == $past(link_rx));
  endsequence

  // idle write reaches the active flag quickly
  AST_TX_LAUNCH: assert property (@(posedge clk) disable iff (!reset_n)
    seq_write_idle |-> seq_active_soon)
    else $error("write did not launch frame");

  // every frame end while powered loads the receive buffer, overrun or not
  AST_RXBUF_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
    seq_frame_end |-> seq_buffer_loaded)
    else $error("receive buffer not loaded");

  // continuous launch raises the tx enable pulse
  AST_TXIRQ_CONT: assert property (@(posedge clk) disable iff (!reset_n)
    (unit_power_enable && can_start && tx_full_q && tx_mode && transfer_mode_select)
      |=> tx_enable_irq)
    else $error("no tx irq on continuous load");

  // tx enable is a one-cycle pulse
  AST_TXIRQ_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
    tx_enable_irq |=> !tx_enable_irq)
    else $error("tx irq longer than one cycle");

  // clean completion while powered always interrupts
  AST_RXIRQ_DONE: assert property (@(posedge clk) disable iff (!reset_n)
    (done_ev && unit_power_enable && !(rx_unread_q && receive_enable_bit))
      |=> rx_complete_irq)
    else $error("no rx irq at completion");

  // completion irq only follows a frame end
  AST_RXIRQ_SRC: assert property (@(posedge clk) disable iff (!reset_n)
    rx_complete_irq |-> $past(done_ev))
    else $error("rx irq without frame end");

  // single-mode overrun sets the flag but stays quiet
  AST_SINGLE_OVR_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
    (done_ev && unit_power_enable && rx_unread_q && receive_enable_bit
     && !transfer_mode_select) |=> (overrun_flag && !rx_complete_irq))
    else $error("single overrun handled wrongly");

  // decoded length stays within the legal span
  AST_LEN_RANGE: assert property (@(posedge clk) disable iff (!reset_n)
    (nbits_d >= BITS_MIN) && (nbits_d <= BITS_MAX))
    else $error("frame length out of range");

  // zero length field means the shortest frame
  AST_LEN_BASE: assert property (@(posedge clk) disable iff (!reset_n)
    (bit_length_field == 4'h0) |-> (nbits_d == BITS_MIN))
    else $error("zero length field not eight bits");

  // receive-only takes no transmit write
  AST_RXONLY_NO_TX: assert property (@(posedge clk) disable iff (!reset_n)
    rx_only |-> !tx_accept)
    else $error("write accepted in receive-only");

  // active flag only drops at a frame end
  AST_ACTIVE_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (transfer_active_flag && !done_ev) |=> transfer_active_flag)
    else $error("active flag dropped mid-frame");

  // continuous receive relaunches while continue is set
  AST_CONT_RELAUNCH: assert property (@(posedge clk) disable iff (!reset_n)
    (done_ev && unit_power_enable && rx_only && transfer_mode_select
     && clock_continue_enable) |=> transfer_active_flag)
    else $error("continuous receive did not relaunch");

  // power off clears overrun and the held word
  AST_OFF_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)
    !unit_power_enable |=> (!overrun_flag && !tx_full_q))
    else $error("power off left state behind");

  // a frame never outlives the cycle bound
  AST_FRAME_BOUNDED: assert property (@(posedge clk) disable iff (!reset_n)
    frame_cyc_q != FRAME_CYC_MAX)
    else $error("frame did not finish in time");
endmodule

// File: csms_pkg.sv
// shared constants for the clocked serial master sequencer
package csms_pkg;
  localparam int DATA_W          = 16;
  localparam int LEN_W           = 4;
  localparam logic [4:0] BITS_MIN = 5'h08;
  localparam logic [4:0] BITS_MAX = 5'h10;
  localparam logic [15:0] RX_RESET = 16'h0000;
  localparam logic [15:0] TX_RESET = 16'h0000;
  localparam int LEN_FULL_BIT    = 3;
  localparam int SYNC_STAGES     = 2;
  localparam logic [11:0] FRAME_CYC_MAX = 12'h400;
endpackage

// File: csms_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
module csms_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// File: csms_shifter.sv
// link-domain shift engine: runs one frame per start toggle
`timescale 1ns/1ps
module csms_shifter
  import csms_pkg::*;
(
  input  wire logic              link_clk,
  input  wire logic              reset_n,
  input  wire logic              start_tgl,
  input  wire logic [DATA_W-1:0] tx_word,
  input  wire logic [4:0]        nbits,
  input  wire logic              lsb_first,
  input  wire logic              sdi,
  output logic                   sck,
  output logic                   sdo,
  output logic                   done_tgl,
  output logic [DATA_W-1:0]      rx_word
);
  logic              start_s;
  logic              seen_q;
  logic              busy_q;
  logic              phase_q;
  logic [4:0]        cnt_q;
  logic [DATA_W-1:0] sh_q;

  csms_sync u_sync (
    .clk     (link_clk),
    .reset_n (reset_n),
    .din     (start_tgl),
    .dout    (start_s)
  );

  // frame engine; config words are stable while a frame runs
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_q   <= 1'b0;
      busy_q   <= 1'b0;
      phase_q  <= 1'b0;
      cnt_q    <= 5'h00;
      sh_q     <= TX_RESET;
      sck      <= 1'b1;
      sdo      <= 1'b0;
      done_tgl <= 1'b0;
      rx_word  <= RX_RESET;
    end else if (!busy_q) begin
      sck <= 1'b1;
      if (start_s != seen_q) begin
        seen_q  <= start_s;
        busy_q  <= 1'b1;
        phase_q <= 1'b0;
        cnt_q   <= 5'h00;
        sh_q    <= tx_word;
        sdo     <= lsb_first ? tx_word[0] : tx_word[nbits[3:0] - 4'h1];
      end
    end else if (!phase_q) begin
      // data moves on the fall so the slave sees it settled at the rise
      sck     <= 1'b0;
      phase_q <= 1'b1;
      if (cnt_q != 5'h00) begin
        sdo <= lsb_first ? sh_q[0] : sh_q[nbits[3:0] - 4'h1];
      end
    end else begin
      // rising edge samples; last edge ends the frame
      sck     <= 1'b1;
      phase_q <= 1'b0;
      cnt_q   <= cnt_q + 5'h01;
      if (lsb_first) begin
        sh_q <= {sdi, sh_q[DATA_W-1:1]};
      end else begin
        sh_q <= {sh_q[DATA_W-2:0], sdi};
      end
      if (cnt_q + 5'h01 == nbits) begin
        busy_q   <= 1'b0;
        done_tgl <= ~done_tgl;
        // right-aligned; unused upper bits come back zero
        rx_word  <= lsb_first ? ({sdi, sh_q[DATA_W-1:1]} >> (BITS_MAX - nbits))
                              : ({sh_q[DATA_W-2:0], sdi}
                                 & ((16'h0001 << nbits) - 16'h0001));
      end
    end
  end
endmodule

// File: csms_slave_model.sv
// behavioural serial slave: replies a rising word sequence, captures master data
`timescale 1ns/1ps
module csms_slave_model (
  input  wire logic        sck,
  input  wire logic        sdo,
  input  wire logic        load,
  input  wire logic        lsb_first,
  input  wire logic [4:0]  nbits,
  input  wire logic [15:0] base,
  output logic             sdi,
  output logic [15:0]      captured
);
  int          cnt;
  logic [15:0] word;
  logic [15:0] cap;
  ////////////////////////////////////////////////////////////////////////////////
  // bench arms a new reply sequence
  always @(posedge load) begin
    word = base;
    cnt = 0;
    sdi = 1'b0;
    captured = 16'h0000;
  end
  // reply bit moves on the fall so it is settled at the sampling rise
  always @(negedge sck) begin
    sdi = lsb_first ? word[cnt] : word[nbits - 1 - cnt];
  end
  // capture on the rise; after the last bit the line no longer holds its value
  always @(posedge sck) begin
    if (cnt == 0) cap = 16'h0000;
    cap[lsb_first ? cnt : nbits - 1 - cnt] = sdo;
    cnt++;
    if (cnt >= nbits) begin
      captured = cap;
      word++;
      cnt = 0;
      sdi = ~sdi;
    end
  end
endmodule

// File: csms_top_tb.sv
// self-checking bench for the clocked serial master sequencer
`timescale 1ns/1ps
module csms_top_tb;
  import csms_pkg::*;
  logic        clk, reset_n, link_clk, pwr, transmit_enable_bit_alias, rxe, cce, dir, tms, dap;
  logic        tx_write, rx_read, ov_wr, ov_wd, sdi, load, act, ovf, txirq, rxirq, sck, sdo;
  logic [3:0]  len;
  logic [4:0]  nb;
  logic [15:0] tx_wdata, rbuf, cap, base, msk, d;
  logic [15:0] expq[$];
  int          n_errors, n_tests, n_tx, n_rx, seed, k, i, n;
  assign nb = len[3] ? 5'h10 : 5'h08 + {2'h0, len[2:0]};
  assign msk = 16'hffff >> (5'h10 - nb);
  csms_top u_dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .unit_power_enable(pwr),
    .transmit_enable_bit(transmit_enable_bit_alias), .receive_enable_bit(rxe), .clock_continue_enable(cce),
    .bit_order_select(dir), .transfer_mode_select(tms), .data_phase_select(dap),
    .bit_length_field(len), .tx_write(tx_write), .tx_wdata(tx_wdata), .rx_read(rx_read),
    .overrun_write(ov_wr), .overrun_wdata(ov_wd), .sdi(sdi), .receive_buffer(rbuf),
    .transfer_active_flag(act), .overrun_flag(ovf), .tx_enable_irq(txirq),
    .rx_complete_irq(rxirq), .sck(sck), .sdo(sdo));
  csms_slave_model u_slave (.sck(sck), .sdo(sdo), .load(load), .lsb_first(dir),
    .nbits(nb), .base(base), .sdi(sdi), .captured(cap));
  ////////////////////////////////////////////////////////////////////////////////
  // system clock 200 MHz; link clock 32 ns with its own phase
  always #2.5 clk = ~clk;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic test_done;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // mode fields go in while powered off, enables merged with power-on
  task automatic cfg(input logic t, r, c, dr, m, p, input logic [3:0] l);
    for (i = 0; i < 800 && act !== 1'b0; i++) @(posedge clk);
    @(posedge clk) begin
      pwr <= 1'b0;
      tms <= m;
      dap <= p;
      len <= l;
    end
    @(posedge clk) begin
      {transmit_enable_bit_alias, rxe, cce, dir} <= {t, r, c, dr};
      pwr <= 1'b1;
      base <= $random(seed);
    end
    @(posedge clk) load <= 1'b1;
    @(posedge clk) load <= 1'b0;
    k = 0;
  endtask
  task automatic exp_next;
    expq.push_back((base + 16'(k)) & msk);
    k++;
  endtask
  task automatic wr(input logic [15:0] v);
    @(posedge clk) begin
      tx_write <= 1'b1;
      tx_wdata <= v;
    end
    @(posedge clk) tx_write <= 1'b0;
  endtask
  task automatic rd;
    @(posedge clk) rx_read <= 1'b1;
    @(posedge clk) rx_read <= 1'b0;
  endtask
  // bounded wait on the completion interrupt count
  task automatic wait_rx(input int m);
    for (i = 0; i < 800 && n_rx < m; i++) @(posedge clk);
    chk(n_rx == m, "rx irq count");
  endtask
  // result watcher: each completion takes the oldest expected word
  always @(negedge clk) begin
    if (txirq === 1'b1) n_tx++;
    if (rxirq === 1'b1) begin
      n_rx++;
      if (expq.size() == 0) chk(1'b0, "unexpected rx irq");
      else chk(rbuf === expq.pop_front(), "receive buffer");
    end
  end
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  initial begin
    clk = 1'b0;
    {reset_n, pwr, transmit_enable_bit_alias, rxe, cce, dir, tms, dap, tx_write, rx_read, ov_wr, ov_wd, load} = '0;
    len = 4'h0;
    tx_wdata = 16'h0000;
    base = 16'h0000;
    seed = 60;
    repeat (2) @(posedge link_clk);
    @(posedge clk) reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(act === 1'b0 && ovf === 1'b0 && sck === 1'b1 && rbuf === RX_RESET, "reset state");
    // single transmit/receive over every length and both bit orders
    for (n = 0; n < 9; n++) begin
      cfg(1'b1, 1'b1, 1'b1, n[0], 1'b0, 1'b0, (n == 8) ? 4'hf : 4'(n));
      d = $random(seed);
      exp_next();
      wr(d);
      repeat (2) @(negedge clk);
      chk(act === 1'b1, "active after write");
      wait_rx(n_rx + 1);
      chk(act === 1'b0, "active cleared at end");
      chk(cap === (d & msk), "slave data");
      rd();
      repeat (20) @(posedge clk);
      chk(act === 1'b0, "read starts nothing");
    end
    chk(n_tx == 0, "no tx irq in single");
    // single, data phase set: a write while active is dropped
    cfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
    exp_next();
    wr($random(seed));
    repeat (4) @(posedge clk);
    wr($random(seed));
    wait_rx(n_rx + 1);
    repeat (300) @(posedge clk);
    // single receive-only: dummy read, read-retrigger, continue cleared
    cfg(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h3);
    exp_next();
    rd();
    wait_rx(n_rx + 1);
    exp_next();
    rd();
    wait_rx(n_rx + 1);
    @(posedge clk) cce <= 1'b0;
    rd();
    repeat (300) @(posedge clk);
    chk(act === 1'b0, "no reception after continue cleared");
    // continuous transmit/receive, next word loaded on tx irq
    cfg(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
    n = n_tx;
    exp_next();
    exp_next();
    wr($random(seed));
    for (i = 0; i < 800 && n_tx == n; i++) @(posedge clk);
    chk(n_tx > n, "tx irq in continuous");
    d = $random(seed);
    wr(d);
    wait_rx(n_rx + 1);
    rd();
    wait_rx(n_rx + 1);
    rd();
    chk(cap === (d & msk), "second word on the wire");
    // continuous receive overrun and flag clearing
    cfg(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
    exp_next();
    exp_next();
    rd();
    wait_rx(n_rx + 1);
    @(posedge clk) cce <= 1'b0;
    wait_rx(n_rx + 1);
    chk(ovf === 1'b1, "overrun set");
    @(posedge clk) {ov_wr, ov_wd} <= 2'b11;
    @(posedge clk) ov_wr <= 1'b0;
    @(negedge clk) chk(ovf === 1'b1, "write one ignored");
    @(posedge clk) {ov_wr, ov_wd} <= 2'b10;
    @(posedge clk) ov_wr <= 1'b0;
    @(negedge clk) chk(ovf === 1'b0, "write zero clears");
    rd();
    repeat (300) @(posedge clk);
    chk(act === 1'b0, "stopped after last word");
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    chk(expq.size() == 0, "all results seen");
    test_done();
  end
endmodule
